// [fcs_pkg.sv]
// Shared constants and types for the flow credit status block.
package fcs_pkg;

  // Credit info selector codes.
  typedef enum logic [2:0] {
    FCS_SEL_RX_AVAIL = 3'b000,
    FCS_SEL_RX_LIMIT = 3'b001,
    FCS_SEL_RX_CONS = 3'b010,
    FCS_SEL_RSVD0 = 3'b011,
    FCS_SEL_TX_AVAIL = 3'b100,
    FCS_SEL_TX_LIMIT = 3'b101,
    FCS_SEL_TX_CONS = 3'b110,
    FCS_SEL_RSVD1 = 3'b111
  } fcs_sel_t;

  // Traffic type codes; they also index the per-type pool arrays.
  localparam logic [1:0] FCS_TYPE_POSTED = 2'h0;
  localparam logic [1:0] FCS_TYPE_NONPOSTED = 2'h1;
  localparam logic [1:0] FCS_TYPE_COMPLETION = 2'h2;

  localparam int FCS_NUM_TYPES = 3;
  localparam int FCS_HDR_W = 8;
  localparam int FCS_DATA_W = 12;
  localparam int FCS_DW_W = 11;

  // Local receive buffer sizes advertised at flow control init, ordered posted, non-posted, completion.
  localparam logic [7:0] FCS_RX_HDR_INIT [3] = '{8'h20, 8'h0c, 8'h24};
  localparam logic [11:0] FCS_RX_DATA_INIT [3] = '{12'h09a, 12'h00c, 12'h09a};
  // Pools advertised as infinite by this device; completions for an endpoint.
  localparam logic [2:0] FCS_RX_INFINITE = 3'h4;

  // Values shown for a partner pool advertised as infinite.
  localparam logic [7:0] FCS_HDR_INF_VAL = 8'h7f;
  localparam logic [11:0] FCS_DATA_INF_VAL = 12'h7ff;

  // Selector to credit output delay in clock cycles.
  localparam int FCS_SEL_LATENCY = 2;

endpackage

// [fcs_pool_ctr.sv]
// Limit and consumed counters for one credit pool.
`timescale 1ns/1ps

module fcs_pool_ctr #(
  parameter int W = 8,
  parameter logic [W-1:0] LIM_RST = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load_lim,
  input wire logic [W-1:0] lim_val,
  input wire logic inc_lim,
  input wire logic [W-1:0] lim_inc,
  input wire logic clr_cons,
  input wire logic inc_cons,
  input wire logic [W-1:0] cons_inc,
  output logic [W-1:0] limit,
  output logic [W-1:0] consumed
);

  logic [W-1:0] lim_q, lim_d;
  logic [W-1:0] cons_q, cons_d;

  // Counters wrap modulo 2^W, as flow control arithmetic expects.
  always_comb begin
    lim_d = lim_q;
    cons_d = cons_q;
    if (load_lim) begin
      lim_d = lim_val;
    end else if (inc_lim) begin
      lim_d = lim_q + lim_inc;
    end
    if (clr_cons) begin
      cons_d = '0;
    end else if (inc_cons) begin
      cons_d = cons_q + cons_inc;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lim_q <= LIM_RST;
      cons_q <= '0;
    end else begin
      lim_q <= lim_d;
      cons_q <= cons_d;
    end
  end

  assign limit = lim_q;
  assign consumed = cons_q;

endmodule

// [fcs_tx_slot.sv]
// One-packet holding slot for the transmit scheduler.
`timescale 1ns/1ps

module fcs_tx_slot (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [1:0] load_type,
  input wire logic [10:0] load_dw,
  input wire logic take,
  output logic valid,
  output logic [1:0] pkt_type,
  output logic [10:0] pkt_dw
);

  logic valid_q, valid_d;
  logic [1:0] type_q, type_d;
  logic [10:0] dw_q, dw_d;

  always_comb begin
    valid_d = valid_q;
    type_d = type_q;
    dw_d = dw_q;
    if (take) begin
      valid_d = 1'b0;
    end
    if (load) begin
      valid_d = 1'b1;
      type_d = load_type;
      dw_d = load_dw;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      valid_q <= 1'b0;
      type_q <= 2'h0;
      dw_q <= 11'h000;
    end else begin
      valid_q <= valid_d;
      type_q <= type_d;
      dw_q <= dw_d;
    end
  end

  assign valid = valid_q;
  assign pkt_type = type_q;
  assign pkt_dw = dw_q;

endmodule

// [fcs_credit_status.sv]
// Flow control credit pools, transmit ordering and the selectable credit status outputs.
`timescale 1ns/1ps

// Contract
// - Decode selector into six categories, two reserved.
// - Outputs follow selector exactly two cycles later.
// - Header credit per packet, data per 16 bytes.
// - Initial credit values valid at link up.
// - Header 8 bits, data 12, top half negative.
// - Only transmit space shows negative or infinite maximum.
// - Receive space shows local free space, floor zero.
// - Receive limit grows as packets drain.
// - Infinite receive pools report zero limit.
// - Receive consumed counts arriving packets from zero.
// - Transmit space shows partner free space, may negative.
// - Posted and completion never pass each other.
// - Posted and completion pass blocked non-posted.
// - Transmit limit follows partner init and updates.
// - Infinite partner pools report zero limit.
// - Transmit consumed counts sent packets from zero.
module fcs_credit_status (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_up,
  input wire logic [2:0] credit_info_select,
  input wire logic rx_pkt_valid,
  input wire logic [1:0] rx_pkt_type,
  input wire logic [10:0] rx_pkt_dw,
  input wire logic rx_read_valid,
  input wire logic [1:0] rx_read_type,
  input wire logic [10:0] rx_read_dw,
  input wire logic partner_fc_valid,
  input wire logic partner_fc_init,
  input wire logic [1:0] partner_fc_type,
  input wire logic [7:0] partner_fc_hdr,
  input wire logic [11:0] partner_fc_data,
  input wire logic tx_req_valid,
  input wire logic [1:0] tx_req_type,
  input wire logic [10:0] tx_req_dw,
  output logic tx_req_ready,
  output logic tx_send_valid,
  output logic [1:0] tx_send_type,
  output logic [10:0] tx_send_dw,
  output logic [7:0] posted_header_credits,
  output logic [11:0] posted_data_credits,
  output logic [7:0] nonposted_header_credits,
  output logic [11:0] nonposted_data_credits,
  output logic [7:0] completion_header_credits,
  output logic [11:0] completion_data_credits
);

  // Data credits of a payload: one per four doublewords, rounded up.
  function automatic logic [11:0] data_credits(input logic [10:0] dw);
    logic [11:0] s;
    s = {1'b0, dw} + 12'h003;
    return {2'b00, s[11:2]};
  endfunction

  // True when the partner pool can take one header and the given data credits.
  function automatic logic credit_ok(input logic [7:0] hl, input logic [7:0] hc, input logic [11:0] dl,
                                     input logic [11:0] dc, input logic hinf, input logic dinf,
                                     input logic [11:0] need);
    logic [7:0] hrem;
    logic [11:0] drem;
    hrem = hl - hc - 8'h01;
    drem = dl - dc - need;
    return (hinf || !hrem[7]) && (dinf || !drem[11]);
  endfunction

  logic [7:0] rx_hlim [3];
  logic [7:0] rx_hcons [3];
  logic [11:0] rx_dlim [3];
  logic [11:0] rx_dcons [3];
  logic [7:0] tx_hlim [3];
  logic [7:0] tx_hcons [3];
  logic [11:0] tx_dlim [3];
  logic [11:0] tx_dcons [3];

  logic pc_valid, np_valid;
  logic [1:0] pc_type, np_type;
  logic [10:0] pc_dw, np_dw;
  logic pc_load, np_load, pc_take, np_take;
  logic send_now;
  logic [1:0] send_type;
  logic [10:0] send_dw;
  logic [11:0] send_dcred;

  logic [2:0] hinf_q, hinf_d;
  logic [2:0] dinf_q, dinf_d;

  // Receive limits load their advertised values and receive consumed counts clear while the link is down, so they are valid at link up.
  generate
    for (genvar t = 0; t < fcs_pkg::FCS_NUM_TYPES; t++) begin : g_pool
      logic rx_in, rx_out, fc_hit, snd;
      assign rx_in = rx_pkt_valid && (rx_pkt_type == 2'(t));
      assign rx_out = rx_read_valid && (rx_read_type == 2'(t));
      assign fc_hit = partner_fc_valid && (partner_fc_type == 2'(t));
      assign snd = send_now && (send_type == 2'(t));

      fcs_pool_ctr #(.W(fcs_pkg::FCS_HDR_W), .LIM_RST(fcs_pkg::FCS_RX_HDR_INIT[t])) u_rx_hdr (
        .clk(clk), .rst_b(rst_b),
        .load_lim(!link_up), .lim_val(fcs_pkg::FCS_RX_HDR_INIT[t]),
        .inc_lim(rx_out), .lim_inc(8'h01),
        .clr_cons(!link_up), .inc_cons(rx_in), .cons_inc(8'h01),
        .limit(rx_hlim[t]), .consumed(rx_hcons[t])
      );
      fcs_pool_ctr #(.W(fcs_pkg::FCS_DATA_W), .LIM_RST(fcs_pkg::FCS_RX_DATA_INIT[t])) u_rx_data (
        .clk(clk), .rst_b(rst_b),
        .load_lim(!link_up), .lim_val(fcs_pkg::FCS_RX_DATA_INIT[t]),
        .inc_lim(rx_out), .lim_inc(data_credits(rx_read_dw)),
        .clr_cons(!link_up), .inc_cons(rx_in), .cons_inc(data_credits(rx_pkt_dw)),
        .limit(rx_dlim[t]), .consumed(rx_dcons[t])
      );
      fcs_pool_ctr #(.W(fcs_pkg::FCS_HDR_W), .LIM_RST(8'h00)) u_tx_hdr (
        .clk(clk), .rst_b(rst_b),
        .load_lim(fc_hit), .lim_val(partner_fc_hdr),
        .inc_lim(1'b0), .lim_inc(8'h00),
        .clr_cons(fc_hit && partner_fc_init), .inc_cons(snd), .cons_inc(8'h01),
        .limit(tx_hlim[t]), .consumed(tx_hcons[t])
      );
      fcs_pool_ctr #(.W(fcs_pkg::FCS_DATA_W), .LIM_RST(12'h000)) u_tx_data (
        .clk(clk), .rst_b(rst_b),
        .load_lim(fc_hit), .lim_val(partner_fc_data),
        .inc_lim(1'b0), .lim_inc(12'h000),
        .clr_cons(fc_hit && partner_fc_init), .inc_cons(snd), .cons_inc(send_dcred),
        .limit(tx_dlim[t]), .consumed(tx_dcons[t])
      );
    end
  endgenerate

  // A zero advertised at flow control init marks the partner pool as infinite.
  always_comb begin
    hinf_d = hinf_q;
    dinf_d = dinf_q;
    for (int t = 0; t < fcs_pkg::FCS_NUM_TYPES; t++) begin
      if (partner_fc_valid && partner_fc_init && (partner_fc_type == 2'(t))) begin
        hinf_d[t] = (partner_fc_hdr == 8'h00);
        dinf_d[t] = (partner_fc_data == 12'h000);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hinf_q <= 3'h0;
      dinf_q <= 3'h0;
    end else begin
      hinf_q <= hinf_d;
      dinf_q <= dinf_d;
    end
  end

  // Posted and completion share one in-order slot; non-posted has its own so it can be bypassed.
  assign tx_req_ready = (tx_req_type == fcs_pkg::FCS_TYPE_NONPOSTED) ? !np_valid :
                        (tx_req_type == fcs_pkg::FCS_TYPE_POSTED || tx_req_type == fcs_pkg::FCS_TYPE_COMPLETION) ?
                        !pc_valid : 1'b0;
  assign pc_load = tx_req_valid && tx_req_ready && (tx_req_type != fcs_pkg::FCS_TYPE_NONPOSTED);
  assign np_load = tx_req_valid && tx_req_ready && (tx_req_type == fcs_pkg::FCS_TYPE_NONPOSTED);

  fcs_tx_slot u_pc_slot (
    .clk(clk), .rst_b(rst_b), .load(pc_load), .load_type(tx_req_type), .load_dw(tx_req_dw),
    .take(pc_take), .valid(pc_valid), .pkt_type(pc_type), .pkt_dw(pc_dw)
  );
  fcs_tx_slot u_np_slot (
    .clk(clk), .rst_b(rst_b), .load(np_load), .load_type(tx_req_type), .load_dw(tx_req_dw),
    .take(np_take), .valid(np_valid), .pkt_type(np_type), .pkt_dw(np_dw)
  );

  // The posted/completion head waits for its own credits; non-posted goes only when that head cannot.
  always_comb begin
    pc_take = pc_valid && credit_ok(tx_hlim[pc_type], tx_hcons[pc_type], tx_dlim[pc_type], tx_dcons[pc_type],
                                    hinf_q[pc_type], dinf_q[pc_type], data_credits(pc_dw));
    np_take = !pc_take && np_valid &&
              credit_ok(tx_hlim[np_type], tx_hcons[np_type], tx_dlim[np_type], tx_dcons[np_type],
                        hinf_q[np_type], dinf_q[np_type], data_credits(np_dw));
    send_now = pc_take || np_take;
    send_type = pc_take ? pc_type : np_type;
    send_dw = pc_take ? pc_dw : np_dw;
    send_dcred = data_credits(send_dw);
  end

  logic send_valid_q, send_valid_d;
  logic [1:0] send_type_q, send_type_d;
  logic [10:0] send_dw_q, send_dw_d;

  always_comb begin
    send_valid_d = send_now;
    send_type_d = send_now ? send_type : send_type_q;
    send_dw_d = send_now ? send_dw : send_dw_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      send_valid_q <= 1'b0;
      send_type_q <= 2'h0;
      send_dw_q <= 11'h000;
    end else begin
      send_valid_q <= send_valid_d;
      send_type_q <= send_type_d;
      send_dw_q <= send_dw_d;
    end
  end

  assign tx_send_valid = send_valid_q;
  assign tx_send_type = send_type_q;
  assign tx_send_dw = send_dw_q;

  // Selector is registered once, the chosen values once more: two cycles in all.
  logic [2:0] sel_q, sel_d;
  logic [7:0] hdr_q [3];
  logic [7:0] hdr_d [3];
  logic [11:0] dat_q [3];
  logic [11:0] dat_d [3];

  always_comb begin
    logic [7:0] pend_h;
    logic [11:0] pend_d;
    logic [7:0] hval;
    logic [11:0] dval;
    pend_h = 8'h00;
    pend_d = 12'h000;
    hval = 8'h00;
    dval = 12'h000;
    sel_d = credit_info_select;
    for (int t = 0; t < fcs_pkg::FCS_NUM_TYPES; t++) begin
      pend_h = 8'h00;
      pend_d = 12'h000;
      if (pc_valid && pc_type == 2'(t)) begin
        pend_h = pend_h + 8'h01;
        pend_d = pend_d + data_credits(pc_dw);
      end
      if (np_valid && np_type == 2'(t)) begin
        pend_h = pend_h + 8'h01;
        pend_d = pend_d + data_credits(np_dw);
      end
      hdr_d[t] = 8'h00;
      dat_d[t] = 12'h000;
      unique case (fcs_pkg::fcs_sel_t'(sel_q))
        fcs_pkg::FCS_SEL_RX_AVAIL: begin
          hval = rx_hlim[t] - rx_hcons[t];
          dval = rx_dlim[t] - rx_dcons[t];
          hdr_d[t] = hval[7] ? 8'h00 : hval;
          dat_d[t] = dval[11] ? 12'h000 : dval;
        end
        fcs_pkg::FCS_SEL_RX_LIMIT: begin
          hdr_d[t] = fcs_pkg::FCS_RX_INFINITE[t] ? 8'h00 : rx_hlim[t];
          dat_d[t] = fcs_pkg::FCS_RX_INFINITE[t] ? 12'h000 : rx_dlim[t];
        end
        fcs_pkg::FCS_SEL_RX_CONS: begin
          hdr_d[t] = rx_hcons[t];
          dat_d[t] = rx_dcons[t];
        end
        fcs_pkg::FCS_SEL_TX_AVAIL: begin
          // Queued but unsent packets count against the partner, so the value can go negative.
          hdr_d[t] = hinf_q[t] ? fcs_pkg::FCS_HDR_INF_VAL : tx_hlim[t] - tx_hcons[t] - pend_h;
          dat_d[t] = dinf_q[t] ? fcs_pkg::FCS_DATA_INF_VAL : tx_dlim[t] - tx_dcons[t] - pend_d;
        end
        fcs_pkg::FCS_SEL_TX_LIMIT: begin
          hdr_d[t] = hinf_q[t] ? 8'h00 : tx_hlim[t];
          dat_d[t] = dinf_q[t] ? 12'h000 : tx_dlim[t];
        end
        fcs_pkg::FCS_SEL_TX_CONS: begin
          hdr_d[t] = tx_hcons[t];
          dat_d[t] = tx_dcons[t];
        end
        fcs_pkg::FCS_SEL_RSVD0, fcs_pkg::FCS_SEL_RSVD1: begin
          hdr_d[t] = 8'h00;
          dat_d[t] = 12'h000;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sel_q <= 3'h0;
      for (int t = 0; t < fcs_pkg::FCS_NUM_TYPES; t++) begin
        hdr_q[t] <= 8'h00;
        dat_q[t] <= 12'h000;
      end
    end else begin
      sel_q <= sel_d;
      for (int t = 0; t < fcs_pkg::FCS_NUM_TYPES; t++) begin
        hdr_q[t] <= hdr_d[t];
        dat_q[t] <= dat_d[t];
      end
    end
  end

  assign posted_header_credits = hdr_q[fcs_pkg::FCS_TYPE_POSTED];
  assign posted_data_credits = dat_q[fcs_pkg::FCS_TYPE_POSTED];
  assign nonposted_header_credits = hdr_q[fcs_pkg::FCS_TYPE_NONPOSTED];
  assign nonposted_data_credits = dat_q[fcs_pkg::FCS_TYPE_NONPOSTED];
  assign completion_header_credits = hdr_q[fcs_pkg::FCS_TYPE_COMPLETION];
  assign completion_data_credits = dat_q[fcs_pkg::FCS_TYPE_COMPLETION];

endmodule

// [fcs_credit_status_sva.sv]
// Port checker for the flow credit status block.
`timescale 1ns/1ps
module fcs_credit_status_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] credit_info_select,
  input wire logic tx_req_valid,
  input wire logic [1:0] tx_req_type,
  input wire logic tx_req_ready,
  input wire logic tx_send_valid,
  input wire logic [1:0] tx_send_type,
  input wire logic [7:0] posted_header_credits,
  input wire logic [11:0] posted_data_credits,
  input wire logic [7:0] nonposted_header_credits,
  input wire logic [11:0] nonposted_data_credits,
  input wire logic [7:0] completion_header_credits,
  input wire logic [11:0] completion_data_credits
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic cpl_take;
  logic cpl_sent;
  assign cpl_take = tx_req_valid && tx_req_ready && tx_req_type == fcs_pkg::FCS_TYPE_COMPLETION;
  assign cpl_sent = tx_send_valid && tx_send_type == fcs_pkg::FCS_TYPE_COMPLETION;
  property p_rsvd_zero;
    $past(credit_info_select, 2) inside {3'h3, 3'h7} |-> posted_header_credits == 8'h00
      && posted_data_credits == 12'h000 && completion_header_credits == 8'h00;
  endproperty
  property p_rx_lim_inf;
    $past(credit_info_select, 2) == 3'h1 |-> completion_header_credits == 8'h00 && completion_data_credits == 12'h000;
  endproperty
  property p_nonneg;
    $past(credit_info_select, 2) inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6} |-> !posted_header_credits[7]
      && !nonposted_header_credits[7] && !completion_header_credits[7] && !posted_data_credits[11];
  endproperty
  property p_avail_cap;
    $past(credit_info_select, 2) == 3'h0 |-> posted_header_credits <= fcs_pkg::FCS_RX_HDR_INIT[0]
      && nonposted_header_credits <= fcs_pkg::FCS_RX_HDR_INIT[1] && posted_data_credits <= fcs_pkg::FCS_RX_DATA_INIT[0];
  endproperty
  property p_send_type;
    tx_send_valid |-> tx_send_type != 2'h3;
  endproperty
  property p_pc_order;
    cpl_take |=> !(tx_send_valid && tx_send_type == fcs_pkg::FCS_TYPE_POSTED) until cpl_sent;
  endproperty
  property p_pc_done;
    cpl_take |-> ##[2:200] cpl_sent;
  endproperty
  property p_slot_full;
    tx_req_valid && tx_req_ready && tx_req_type == fcs_pkg::FCS_TYPE_POSTED |=>
      !(tx_req_type == fcs_pkg::FCS_TYPE_COMPLETION && tx_req_ready);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved code output not zero");
  a_rx_lim_inf: assert property (p_rx_lim_inf) else $error("infinite receive limit not zero");
  a_nonneg: assert property (p_nonneg) else $error("negative value outside transmit space");
  a_avail_cap: assert property (p_avail_cap) else $error("receive space above initial value");
  a_send_type: assert property (p_send_type) else $error("unknown packet type sent");
  a_pc_order: assert property (p_pc_order) else $error("posted passed completion");
  a_pc_done: assert property (p_pc_done) else $error("completion never sent");
  a_slot_full: assert property (p_slot_full) else $error("completion taken behind posted");
  c_post: cover property (tx_send_valid && tx_send_type == fcs_pkg::FCS_TYPE_POSTED);
  c_inf: cover property ($past(credit_info_select, 2) == 3'h4 && nonposted_header_credits == 8'h7f);
  c_block: cover property (tx_req_valid && !tx_req_ready);
endmodule

bind fcs_credit_status fcs_credit_status_chk i_chk (.clk, .rst_b, .credit_info_select, .tx_req_valid,
  .tx_req_type, .tx_req_ready, .tx_send_valid, .tx_send_type, .posted_header_credits, .posted_data_credits,
  .nonposted_header_credits, .nonposted_data_credits, .completion_header_credits, .completion_data_credits);

// [fcs_user_model.sv]
// User side model that selects credit categories and offers transmit packets.
`timescale 1ns/1ps
module fcs_user_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] sel_in,
  input wire logic go,
  input wire logic [1:0] go_type,
  input wire logic [10:0] go_dw,
  input wire logic tx_req_ready,
  output logic [2:0] credit_info_select,
  output logic tx_req_valid,
  output logic [1:0] tx_req_type,
  output logic [10:0] tx_req_dw
);
  initial begin
    credit_info_select = 3'h0;
    tx_req_valid = 1'b0;
    tx_req_type = 2'h3;
    tx_req_dw = 11'h000;
  end
  // A released request shows inverted fields so stale values are never mistaken for live ones.
  always @(posedge clk) begin
    credit_info_select <= sel_in;
    if (!rst_b) begin
      tx_req_valid <= 1'b0;
    end else if (tx_req_valid && tx_req_ready) begin
      tx_req_valid <= 1'b0;
      tx_req_type <= ~tx_req_type;
      tx_req_dw <= ~tx_req_dw;
    end else if (go && !tx_req_valid) begin
      tx_req_valid <= 1'b1;
      tx_req_type <= go_type;
      tx_req_dw <= go_dw;
    end
  end
endmodule

// [tb_top.sv]
// Self-checking testbench for the flow credit status block.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED at %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic clk, rst_b, link_up, rx_pkt_valid, rx_read_valid, partner_fc_valid, partner_fc_init, go;
  logic [2:0] sel_in, credit_info_select;
  logic [1:0] rx_pkt_type, rx_read_type, partner_fc_type, go_type, tx_req_type, tx_send_type;
  logic [10:0] rx_pkt_dw, rx_read_dw, go_dw, tx_req_dw, tx_send_dw, da, db;
  logic [7:0] partner_fc_hdr, posted_header_credits, nonposted_header_credits, completion_header_credits, lf;
  logic [11:0] partner_fc_data, posted_data_credits, nonposted_data_credits, completion_data_credits;
  logic tx_req_valid, tx_req_ready, tx_send_valid, pv, p1, p2, p3;
  logic [59:0] cr, ce;
  logic [12:0] se;
  logic [59:0] cq[$];
  logic [12:0] sq[$];
  int bad_count, tests_run, cyc;
  assign cr = {posted_header_credits, posted_data_credits, nonposted_header_credits, nonposted_data_credits,
    completion_header_credits, completion_data_credits};
  fcs_credit_status i_dut (.clk, .rst_b, .link_up, .credit_info_select, .rx_pkt_valid, .rx_pkt_type, .rx_pkt_dw,
    .rx_read_valid, .rx_read_type, .rx_read_dw, .partner_fc_valid, .partner_fc_init, .partner_fc_type,
    .partner_fc_hdr, .partner_fc_data, .tx_req_valid, .tx_req_type, .tx_req_dw, .tx_req_ready, .tx_send_valid,
    .tx_send_type, .tx_send_dw, .posted_header_credits, .posted_data_credits, .nonposted_header_credits,
    .nonposted_data_credits, .completion_header_credits, .completion_data_credits);
  fcs_user_model i_user (.clk, .rst_b, .sel_in, .go, .go_type, .go_dw, .tx_req_ready, .credit_info_select,
    .tx_req_valid, .tx_req_type, .tx_req_dw);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [59:0] pk(input logic [7:0] a, input logic [11:0] b, input logic [7:0] c,
    input logic [11:0] d, input logic [7:0] e, input logic [11:0] f);
    return {a, b, c, d, e, f};
  endfunction
  function automatic logic [11:0] dc(input logic [10:0] dw);
    return ({1'b0, dw} + 12'h003) >> 2;
  endfunction
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic report_and_stop;
    $display("counts tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic look(input logic [2:0] s, input logic [59:0] e);
    @(posedge clk);
    sel_in <= s;
    pv <= 1'b1;
    cq.push_back(e);
  endtask
  task automatic idle(input int n);
    @(posedge clk);
    pv <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic rx(input logic rd, input logic [1:0] t, input logic [10:0] dw);
    @(posedge clk);
    if (rd) begin
      {rx_read_valid, rx_read_type, rx_read_dw} <= {1'b1, t, dw};
    end else begin
      {rx_pkt_valid, rx_pkt_type, rx_pkt_dw} <= {1'b1, t, dw};
    end
    @(posedge clk);
    {rx_read_valid, rx_pkt_valid} <= 2'h0;
    {rx_read_dw, rx_pkt_dw} <= {~rx_read_dw, ~rx_pkt_dw};
  endtask
  task automatic fc(input logic i, input logic [1:0] t, input logic [7:0] h, input logic [11:0] d);
    @(posedge clk);
    {partner_fc_valid, partner_fc_init, partner_fc_type, partner_fc_hdr, partner_fc_data} <= {1'b1, i, t, h, d};
    @(posedge clk);
    partner_fc_valid <= 1'b0;
    {partner_fc_hdr, partner_fc_data} <= {~h, ~d};
  endtask
  task automatic send(input logic [1:0] t, input logic [10:0] dw, input logic note);
    @(posedge clk);
    {go, go_type, go_dw} <= {1'b1, t, dw};
    if (note) sq.push_back({t, dw});
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic drain;
    for (int n = 0; n < 60 && sq.size() != 0; n++) @(posedge clk);
  endtask
  always @(posedge clk) begin
    {p1, p2, p3} <= {pv, p1, p2};
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      bad_count++;
      report_and_stop;
    end
  end
  always @(negedge clk) begin
    if (p3 === 1'b1) begin
      ce = cq.pop_front();
      `CHK(cr, ce)
    end
    if (tx_send_valid === 1'b1) begin
      se = sq.size() != 0 ? sq.pop_front() : 13'h1fff;
      `CHK({tx_send_type, tx_send_dw}, se)
    end
  end
  initial begin
    {rst_b, link_up, rx_pkt_valid, rx_read_valid, partner_fc_valid, partner_fc_init, go, pv, p1, p2, p3} = '0;
    {sel_in, rx_pkt_type, rx_read_type, partner_fc_type, go_type, rx_pkt_dw, rx_read_dw, go_dw} = '0;
    {partner_fc_hdr, partner_fc_data, cyc, bad_count, tests_run} = '0;
    lf = 8'h2e;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    link_up <= 1'b1;
    look(3'h0, pk(8'h20, 12'h09a, 8'h0c, 12'h00c, 8'h24, 12'h09a));
    look(3'h1, pk(8'h20, 12'h09a, 8'h0c, 12'h00c, 8'h00, 12'h000));
    look(3'h2, '0);
    idle(4);
    $display("test rx_init done");
    lf = nx(lf);
    da = {5'h00, lf[5:0]};
    rx(1'b0, 2'h0, da);
    rx(1'b0, 2'h2, 11'h005);
    idle(2);
    look(3'h0, pk(8'h1f, 12'h09a - dc(da), 8'h0c, 12'h00c, 8'h23, 12'h098));
    look(3'h2, pk(8'h01, dc(da), 8'h00, 12'h000, 8'h01, 12'h002));
    idle(4);
    rx(1'b1, 2'h0, da);
    rx(1'b1, 2'h2, 11'h005);
    idle(2);
    look(3'h0, pk(8'h20, 12'h09a, 8'h0c, 12'h00c, 8'h24, 12'h09a));
    look(3'h1, pk(8'h21, 12'h09a + dc(da), 8'h0c, 12'h00c, 8'h00, 12'h000));
    idle(4);
    $display("test rx_traffic done");
    fc(1'b1, 2'h0, 8'h10, 12'h040);
    fc(1'b1, 2'h1, 8'h00, 12'h000);
    fc(1'b1, 2'h2, 8'h08, 12'h020);
    idle(2);
    look(3'h4, pk(8'h10, 12'h040, 8'h7f, 12'h7ff, 8'h08, 12'h020));
    look(3'h5, pk(8'h10, 12'h040, 8'h00, 12'h000, 8'h08, 12'h020));
    look(3'h6, '0);
    idle(4);
    lf = nx(lf);
    db = {5'h00, lf[5:0]};
    send(2'h0, db, 1'b1);
    drain;
    fc(1'b0, 2'h0, 8'h12, 12'h050);
    idle(2);
    look(3'h4, pk(8'h11, 12'h050 - dc(db), 8'h7f, 12'h7ff, 8'h08, 12'h020));
    look(3'h5, pk(8'h12, 12'h050, 8'h00, 12'h000, 8'h08, 12'h020));
    look(3'h6, pk(8'h01, dc(db), 8'h00, 12'h000, 8'h00, 12'h000));
    idle(4);
    $display("test tx_credits done");
    fc(1'b0, 2'h2, 8'h00, 12'h000);
    send(2'h2, 11'h004, 1'b1);
    idle(6);
    send(2'h0, 11'h008, 1'b1);
    idle(3);
    @(negedge clk);
    `CHK(tx_req_ready, 1'b0)
    look(3'h4, pk(8'h11, 12'h050 - dc(db), 8'h7f, 12'h7ff, 8'hff, 12'hfff));
    idle(4);
    fc(1'b0, 2'h2, 8'h08, 12'h020);
    drain;
    $display("test pc_order done");
    fc(1'b1, 2'h1, 8'h01, 12'h001);
    send(2'h1, 11'h001, 1'b1);
    drain;
    send(2'h1, 11'h001, 1'b0);
    idle(4);
    send(2'h0, 11'h004, 1'b1);
    drain;
    sq.push_back({2'h1, 11'h001});
    fc(1'b0, 2'h1, 8'h02, 12'h002);
    drain;
    $display("test np_bypass done");
    link_up <= 1'b0;
    look(3'h2, '0);
    look(3'h1, pk(8'h20, 12'h09a, 8'h0c, 12'h00c, 8'h00, 12'h000));
    idle(4);
    link_up <= 1'b1;
    $display("test link_drop done");
    @(posedge clk);
    sel_in <= 3'h3;
    idle(3);
    sel_in <= 3'h7;
    idle(4);
    `CHK(sq.size(), 0)
    $display("test reserved done");
    report_and_stop;
  end
endmodule
